//--- design/ctl_stage.sv
// One register stage with selectable clock enable and synchronous reset.
// Assumes the enable and reset sources are already on the clk domain.
`timescale 1ns/1ns
`default_nettype none
module ctl_stage
  import mac_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NUM_SRC-1:0] ce_src,
  input wire logic [NUM_SRC-1:0] rst_src,
  input wire logic [SEL_W-1:0] ce_sel,
  input wire logic [SEL_W-1:0] rst_sel,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] data;
  } stage_s;

  stage_s state;
  stage_s next_state;
  logic take;
  logic clear;

  // Reset beats enable so a stalled stage can still be flushed
  assign take = ce_src[ce_sel];
  assign clear = rst_src[rst_sel];

  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.data = {WIDTH{STAGE_RESET_BIT}};
    end else if (take) begin
      next_state.data = d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  stage_clear_a: assert property (clear |=> q == '0)
    else $error("stage did not clear on selected reset");
  stage_load_a: assert property (!clear && take |=> q == $past(d))
    else $error("stage did not load on selected enable");
  stage_hold_a: assert property (!clear && !take |=> $stable(q))
    else $error("stage changed without enable");
endmodule
`default_nettype wire

//--- design/mac_accum.sv
// Multiply-accumulate slice: input, pipeline and accumulator register stages.
// Assumes operands are already extended by fabric logic to the native width.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Each stage selects enable and reset from four
// - Operands natively 9, 18 or 36 bits
// - Accumulator wraps and flags overflow
// - Unsigned overflow when sum below previous value
// - Signed overflow on same-sign inputs, sign flip
// - Overflow is a one-cycle pulse
module mac_accum
  import mac_pkg::*;
#(
  parameter int OP_W = DEF_OP_W,
  parameter int ACC_W = DEF_ACC_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NUM_SRC-1:0] ce_src,
  input wire logic [NUM_SRC-1:0] rst_src,
  input wire logic [SEL_W-1:0] ce_sel_in,
  input wire logic [SEL_W-1:0] rst_sel_in,
  input wire logic [SEL_W-1:0] ce_sel_pipe,
  input wire logic [SEL_W-1:0] rst_sel_pipe,
  input wire logic [SEL_W-1:0] ce_sel_out,
  input wire logic [SEL_W-1:0] rst_sel_out,
  input wire logic signed_mode,
  input wire logic [OP_W-1:0] op_a,
  input wire logic [OP_W-1:0] op_b,
  output logic [ACC_W-1:0] acc,
  output logic overflow
);
  localparam int PROD_W = 2 * OP_W;
  localparam int EXT_W = ACC_W - PROD_W;

  typedef struct packed {
    logic [ACC_W-1:0] sum;
    logic ovf;
  } acc_state_s;

  acc_state_s state;
  acc_state_s next_state;

  // Only native widths are legal; narrower data is extended outside
  logic [2*OP_W:0] in_d;
  logic [2*OP_W:0] in_q;
  logic [OP_W-1:0] a_q;
  logic [OP_W-1:0] b_q;
  logic sgn_in_q;
  logic [PROD_W-1:0] prod_u;
  logic signed [PROD_W-1:0] prod_s;
  logic [PROD_W:0] pipe_d;
  logic [PROD_W:0] pipe_q;
  logic [PROD_W-1:0] prod_q;
  logic sgn_pipe_q;
  logic [ACC_W-1:0] addend;
  logic [ACC_W:0] wide_sum;
  logic unsigned_ovf;
  logic signed_ovf;
  logic out_take;
  logic out_clear;

  assign in_d = {signed_mode, op_a, op_b};

  ctl_stage #(
    .WIDTH(2 * OP_W + 1)
  ) input_stage (
    .clk(clk),
    .arst_n(arst_n),
    .ce_src(ce_src),
    .rst_src(rst_src),
    .ce_sel(ce_sel_in),
    .rst_sel(rst_sel_in),
    .d(in_d),
    .q(in_q)
  );

  assign sgn_in_q = in_q[2*OP_W];
  assign a_q = in_q[2*OP_W-1:OP_W];
  assign b_q = in_q[OP_W-1:0];

  // Both products are formed; the mode bit picks one
  assign prod_u = a_q * b_q;
  assign prod_s = $signed(a_q) * $signed(b_q);
  assign pipe_d = {sgn_in_q, sgn_in_q ? prod_s : prod_u};

  ctl_stage #(
    .WIDTH(PROD_W + 1)
  ) pipe_stage (
    .clk(clk),
    .arst_n(arst_n),
    .ce_src(ce_src),
    .rst_src(rst_src),
    .ce_sel(ce_sel_pipe),
    .rst_sel(rst_sel_pipe),
    .d(pipe_d),
    .q(pipe_q)
  );

  assign sgn_pipe_q = pipe_q[PROD_W];
  assign prod_q = pipe_q[PROD_W-1:0];

  // Extension follows the mode the product was formed in
  assign addend = sgn_pipe_q ? {{EXT_W{prod_q[PROD_W-1]}}, prod_q}
                             : {{EXT_W{1'b0}}, prod_q};

  // Carry out is the same test as result below previous value
  assign wide_sum = {1'b0, state.sum} + {1'b0, addend};
  assign unsigned_ovf = wide_sum[ACC_W];
  assign signed_ovf = (state.sum[ACC_W-1] == addend[ACC_W-1]) &&
                      (wide_sum[ACC_W-1] != state.sum[ACC_W-1]);

  assign out_take = ce_src[ce_sel_out];
  assign out_clear = rst_src[rst_sel_out];

  always_comb begin
    next_state = state;
    // Pulse by default, so a held stage never leaves the flag up
    next_state.ovf = 1'b0;
    if (out_clear) begin
      next_state.sum = '0;
    end else if (out_take) begin
      next_state.sum = wide_sum[ACC_W-1:0];
      // Flag registered with the wrapped sum, same edge
      next_state.ovf = sgn_pipe_q ? signed_ovf : unsigned_ovf;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Wider totals are built by counting these pulses outside
  assign acc = state.sum;
  assign overflow = state.ovf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [ACC_W-1:0] prev_addend;
  logic prev_sgn;
  logic prev_update;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_addend <= '0;
      prev_sgn <= 1'b0;
      prev_update <= 1'b0;
    end else begin
      prev_addend <= addend;
      prev_sgn <= sgn_pipe_q;
      prev_update <= out_take && !out_clear;
    end
  end

  acc_wrap_a: assert property (
    out_take && !out_clear |=> acc == ACC_W'($past(acc) + $past(addend)))
    else $error("accumulator did not wrap to truncated sum");
  acc_clear_a: assert property (out_clear |=> acc == '0 && !overflow)
    else $error("accumulator not cleared by selected reset");
  acc_hold_a: assert property (
    !out_take && !out_clear |=> $stable(acc) && !overflow)
    else $error("accumulator moved without enable");
  unsigned_ovf_a: assert property (
    prev_update && !prev_sgn |-> overflow == (acc < $past(acc)))
    else $error("unsigned overflow not tied to smaller result");
  signed_ovf_a: assert property (
    prev_update && prev_sgn |-> overflow ==
      (($past(acc[ACC_W-1]) == prev_addend[ACC_W-1]) &&
       (acc[ACC_W-1] != $past(acc[ACC_W-1]))))
    else $error("signed overflow not tied to sign flip");
  ovf_cause_a: assert property (overflow |-> prev_update)
    else $error("overflow without accumulator update");
  ovf_same_a: assert property (overflow |-> $changed(acc))
    else $error("overflow not with wrapped result");
  ovf_drop_a: assert property (
    overflow ##0 (!out_take || out_clear) |=> !overflow)
    else $error("overflow stayed beyond one cycle");
  ovf_latency_a: assert property (
    out_take && !out_clear && !sgn_pipe_q && unsigned_ovf |=> overflow [*1])
    else $error("overflow missing one cycle after wrap");
  signed_latency_a: assert property (
    out_take && !out_clear && sgn_pipe_q && signed_ovf |=> overflow)
    else $error("signed overflow missing after wrap");
  quiet_ovf_a: assert property (
    out_take && !out_clear && !(sgn_pipe_q ? signed_ovf : unsigned_ovf) |=> !overflow)
    else $error("overflow raised without wrap");
  no_wrap_a: assert property (
    prev_update && !prev_sgn && !overflow |-> acc >= $past(acc))
    else $error("unsigned sum shrank without overflow");

  // Mode bit must stay paired with its product through the pipe stage
  mode_travel_a: assert property (
    ce_src[ce_sel_pipe] && !rst_src[rst_sel_pipe] |=> sgn_pipe_q == $past(sgn_in_q))
    else $error("mode bit lost between stages");
  unsigned_prod_a: assert property (
    ce_src[ce_sel_pipe] && !rst_src[rst_sel_pipe] && !sgn_in_q |=>
      prod_q == $past(a_q) * $past(b_q))
    else $error("unsigned product wrong");
  signed_prod_a: assert property (
    ce_src[ce_sel_pipe] && !rst_src[rst_sel_pipe] && sgn_in_q |=>
      $signed(prod_q) == $signed($past(a_q)) * $signed($past(b_q)))
    else $error("signed product wrong");

  unsigned_wrap_c: cover property (overflow && !prev_sgn);
  signed_wrap_c: cover property (overflow && prev_sgn);
  back_to_back_c: cover property (overflow ##1 overflow);
  clear_after_c: cover property (overflow ##1 out_clear);
  mode_switch_c: cover property (prev_update && prev_sgn != sgn_pipe_q && out_take);
endmodule
`default_nettype wire

//--- shared/mac_pkg.sv
// Constants shared by the multiply-accumulate slice and its register stages.
// Assumes one fabric clock; all control sources come from logic on that clock.
package mac_pkg;
  // Number of selectable clock-enable and reset sources per stage
  localparam int NUM_SRC = 4;
  localparam int SEL_W = 2;
  // Native operand widths of the multiplier
  localparam int NATIVE_W9 = 9;
  localparam int NATIVE_W18 = 18;
  localparam int NATIVE_W36 = 36;
  // Default operand and accumulator widths
  localparam int DEF_OP_W = NATIVE_W18;
  localparam int DEF_ACC_W = 52;
  // Value every stage register takes on reset
  localparam logic STAGE_RESET_BIT = 1'b0;
  // Cycles from operand capture to accumulator update
  localparam int LAT_IN_TO_PIPE = 1;
  localparam int LAT_PIPE_TO_ACC = 1;
endpackage

//--- tb/fabric_model.sv
// Fabric side model: widens narrow operands and counts overflow pulses.
// Assumes it shares the slice clock and reset.
`timescale 1ns/1ns
`default_nettype none
module fabric_model
  import mac_pkg::*;
#(
  parameter int OP_W = DEF_OP_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sgn,
  input wire logic [4:0] nw,
  input wire logic [OP_W-1:0] raw_a,
  input wire logic [OP_W-1:0] raw_b,
  input wire logic overflow,
  output logic [OP_W-1:0] op_a,
  output logic [OP_W-1:0] op_b,
  output logic [15:0] wraps
);
  // Narrow width passed in, so the assign follows every change
  function automatic logic [OP_W-1:0] ext(input logic [OP_W-1:0] v, input logic [4:0] n,
      input logic s);
    ext = v;
    for (int i = 1; i < OP_W; i++) begin
      if (i >= n) ext[i] = s ? v[n-1] : 1'b0;
    end
  endfunction
  assign op_a = ext(raw_a, nw, sgn);
  assign op_b = ext(raw_b, nw, sgn);
  // Upper accumulator bits built from pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wraps <= 16'h0000;
    else if (overflow) wraps <= wraps + 16'h0001;
  end
endmodule
`default_nettype wire

//--- tb/mac_accumulator_overflow_tb.sv
// Self-checking bench for the multiply-accumulate slice.
// Assumes a reference pipeline of three stages with the hand-over latency.
`timescale 1ns/1ns
`default_nettype none
module mac_accumulator_overflow_tb;
  import mac_pkg::*;
  localparam int OW = NATIVE_W18;
  // Short accumulator so wraps come within a few adds
  localparam int AW = 37;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [NUM_SRC-1:0] ce_src = '0;
  logic [NUM_SRC-1:0] rst_src = '0;
  logic [SEL_W-1:0] sel [6] = '{default: '0};
  logic sgn = 1'b0;
  logic [4:0] nw = 5'h12;
  logic [OW-1:0] ra = '0;
  logic [OW-1:0] rb = '0;
  logic [OW-1:0] op_a, op_b, ia, ib;
  logic [AW-1:0] acc, macc;
  logic ovf, im, pm;
  logic [15:0] wraps;
  logic [2*OW-1:0] pp;
  logic [AW:0] q [$];
  logic [OW-1:0] pa [3] = '{18'h3ffff, 18'h20000, 18'h1ffff};
  logic [OW-1:0] pb [3] = '{18'h3ffff, 18'h20000, 18'h20000};
  int err_total = 0;
  int checked = 0;
  int n_ovf = 0;
  always #4 clk = ~clk;
  mac_accum #(.OP_W(OW), .ACC_W(AW)) dut (.clk(clk), .arst_n(arst_n), .ce_src(ce_src),
    .rst_src(rst_src), .ce_sel_in(sel[0]), .rst_sel_in(sel[1]), .ce_sel_pipe(sel[2]),
    .rst_sel_pipe(sel[3]), .ce_sel_out(sel[4]), .rst_sel_out(sel[5]), .signed_mode(sgn),
    .op_a(op_a), .op_b(op_b), .acc(acc), .overflow(ovf));
  fabric_model #(.OP_W(OW)) fab (.clk(clk), .arst_n(arst_n), .sgn(sgn), .nw(nw),
    .raw_a(ra), .raw_b(rb), .overflow(ovf), .op_a(op_a), .op_b(op_b), .wraps(wraps));
  task automatic check(input logic [AW:0] got, input logic [AW:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input logic [3:0] ce, input logic [3:0] rs, input logic s,
      input logic [4:0] w, input logic [OW-1:0] a, input logic [OW-1:0] b);
    @(posedge clk);
    #1;
    ce_src = ce;
    rst_src = rs;
    sgn = s;
    nw = w;
    ra = a;
    rb = b;
    foreach (sel[i]) sel[i] = SEL_W'($urandom);
  endtask
  // Reference stages, outer stage first so each sees old values
  always @(posedge clk or negedge arst_n) begin
    logic [AW-1:0] pe, s;
    logic o;
    logic [2*OW-1:0] pu;
    logic signed [2*OW-1:0] ps;
    if (!arst_n) begin
      {ia, ib, im, pp, pm, macc} = '0;
      // Notes left over from before a reset would pair with the wrong cycle
      q.delete();
    end else begin
      o = 1'b0;
      // Full-width products; a bare product inside braces keeps only OW bits
      pu = ia * ib;
      ps = $signed(ia) * $signed(ib);
      pe = pm ? AW'(signed'(pp)) : AW'(pp);
      s = macc + pe;
      if (rst_src[sel[5]]) macc = '0;
      else if (ce_src[sel[4]]) begin
        o = pm ? (macc[AW-1] == pe[AW-1] && s[AW-1] != macc[AW-1]) : (s < macc);
        macc = s;
      end
      if (rst_src[sel[3]]) {pp, pm} = '0;
      else if (ce_src[sel[2]]) {pp, pm} = {im ? ps : pu, im};
      if (rst_src[sel[1]]) {ia, ib, im} = '0;
      else if (ce_src[sel[0]]) {ia, ib, im} = {op_a, op_b, sgn};
      q.push_back({o, macc});
    end
  end
  always @(posedge clk) begin
    logic [AW:0] e;
    #1;
    if (arst_n && q.size() > 0) begin
      e = q.pop_front();
      check({ovf, acc}, e);
      if (e[AW]) n_ovf++;
    end
  end
  initial begin
    void'($urandom(32'h04165f79));
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    // Full-width extremes force wraps in both modes, back to back
    for (int p = 0; p < 3; p++) begin
      repeat (12) step(4'hf, 4'h0, p != 0, 5'h12, pa[p], pb[p]);
    end
    repeat (3) step(4'h0, 4'h0, 1'b0, 5'h12, '0, '0);
    check((AW+1)'(wraps), (AW+1)'(n_ovf));
    @(posedge clk);
    #1 arst_n = 1'b0;
    n_ovf = 0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 400; i++) begin
      step(4'($urandom), $urandom_range(0, 5) == 0 ? 4'($urandom) : 4'h0, 1'($urandom),
        5'($urandom_range(1, 18)), OW'($urandom), OW'($urandom));
    end
    // Stall every stage so the pulse count settles before it is compared
    repeat (3) step(4'h0, 4'h0, 1'b0, 5'h12, '0, '0);
    check((AW+1)'(wraps), (AW+1)'(n_ovf));
    repeat (4) @(posedge clk);
    print_verdict();
  end
  initial begin
    #8000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
